// ---- src/seg_addr_gen.sv ----
/*
 * Segmented address generator: four segment registers, implicit and
 * override segment choice, offset sum and 20-bit physical address.
 * Assumes decode logic and the bus interface share clk_i; one request
 * is answered per cycle one clock later.
 */
`timescale 1ns/1ps
`include "seg_addr_params.svh"

// Function
// [R1] A segment spans at most 64K bytes through a 16-bit offset.
// [R2] Every memory reference uses a 16-bit segment base and offset.
// [R3] Four segment registers code, data, stack, extra supply every base.
// [R4] Physical address is base shifted left four plus offset, 20 bits.
// [R5] Code segment serves instruction fetch and immediate data.
// [R6] Data segment serves all other data references.
// [R7] Stack segment serves push, pop and base-pointer based operands.
// [R8] Extra segment serves string destination accesses.
// [R9] Override prefix replaces the implicit segment for the operand.
// [R10] One pointer load reloads a segment and offset register together.
// [R11] Pointer loads put segment into data or extra, offset to register.
// [R12] Stack, data and extra segments may hold equal bases.
// [R13] Offset sum drops carries past 16 bits; 8-bit displacement extends.
// [R14] Physical address carry past bit 19 is dropped.
module seg_addr_gen (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire seg_addr_pkg::addr_req_t req_i,
  input wire logic seg_load_valid_i,
  input wire seg_addr_pkg::seg_load_t seg_load_i,
  input wire logic ptr_load_valid_i,
  input wire seg_addr_pkg::ptr_load_t ptr_load_i,
  output logic rsp_valid_o,
  output seg_addr_pkg::addr_rsp_t rsp_o,
  output logic gen_wr_o,
  output logic [2:0] gen_reg_o,
  output logic [`OFS_W-1:0] gen_val_o
);

  logic rst_sync1;
  logic rst_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync1 <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_b <= rst_sync1;
    end
  end

  // Segment registers
  logic [`SEG_W-1:0] seg_reg [4];
  logic [`SEG_W-1:0] next_seg_reg [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_seg
      // No overlap check between segments, see [R12]
      always_comb begin
        next_seg_reg[g] = seg_reg[g];
        if (seg_load_valid_i &&
            seg_load_i.seg == `SEG_SEL_W'(g)) begin
          next_seg_reg[g] = seg_load_i.value;
        end
        // Pointer load wins for its segment, see [R10] see [R11]
        if (ptr_load_valid_i) begin
          if (ptr_load_i.to_extra && `SEG_SEL_W'(g) == `SEL_EXTRA)
            next_seg_reg[g] = ptr_load_i.seg_part;
          if (!ptr_load_i.to_extra && `SEG_SEL_W'(g) == `SEL_DATA)
            next_seg_reg[g] = ptr_load_i.seg_part;
        end
      end

      always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
          seg_reg[g] <= (g == 0) ? `CODE_SEG_RST : `SEG_RST;
        end else begin
          seg_reg[g] <= next_seg_reg[g];
        end
      end
    end
  endgenerate

  // Segment choice and offset sum
  seg_addr_pkg::seg_sel_t sel;
  logic [`OFS_W-1:0] disp_ext;
  logic [`OFS_W-1:0] eff_ofs;
  logic [`PHYS_W-1:0] phys;

  always_comb begin
    unique case (req_i.kind)
      seg_addr_pkg::REF_FETCH: sel = `SEL_CODE; // see [R5]
      seg_addr_pkg::REF_IMM: sel = `SEL_CODE; // see [R5]
      seg_addr_pkg::REF_STACK: sel = `SEL_STACK; // see [R7]
      seg_addr_pkg::REF_STR_DST: sel = `SEL_EXTRA; // see [R8]
      seg_addr_pkg::REF_DATA:
        sel = req_i.base_is_bp ? `SEL_STACK : `SEL_DATA; // see [R6] [R7]
      default: sel = `SEL_DATA;
    endcase
    // Override applies to operands only, not fetch or string dest
    if (req_i.ovr_valid &&
        (req_i.kind == seg_addr_pkg::REF_DATA ||
         req_i.kind == seg_addr_pkg::REF_STACK && req_i.base_is_bp)) begin
      sel = req_i.ovr_seg; // see [R9]
    end
    disp_ext = req_i.disp_is_8 ?
      {{(`OFS_W-`DISP8_W){req_i.disp[`DISP8_W-1]}},
       req_i.disp[`DISP8_W-1:0]} : req_i.disp; // see [R13]
    // 16-bit sum wraps inside the 64K segment, see [R1] see [R13]
    eff_ofs = req_i.base + req_i.index + disp_ext;
  end

  phys_adder u_phys_adder (
    .seg_base_i(seg_reg[sel]), // see [R2] see [R3]
    .offset_i(eff_ofs),
    .phys_o(phys)
  );

  // Answer registers
  seg_addr_pkg::gen_state_t state;
  seg_addr_pkg::gen_state_t next_state;
  seg_addr_pkg::addr_rsp_t next_rsp;
  logic next_gen_wr;
  logic [2:0] next_gen_reg;
  logic [`OFS_W-1:0] next_gen_val;

  always_comb begin
    next_state = req_valid_i ? seg_addr_pkg::ST_BUSY : seg_addr_pkg::ST_IDLE;
    next_rsp = rsp_o;
    if (req_valid_i) begin
      next_rsp.phys = phys;
      next_rsp.seg = sel;
      next_rsp.offset = eff_ofs;
    end
    next_gen_wr = ptr_load_valid_i; // see [R10] see [R11]
    next_gen_reg = ptr_load_valid_i ? ptr_load_i.gen_reg : gen_reg_o;
    next_gen_val = ptr_load_valid_i ? ptr_load_i.ofs_part : gen_val_o;
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      state <= seg_addr_pkg::ST_IDLE;
      rsp_o <= '{phys: `PHYS_RST, seg: `SEL_CODE, offset: `OFS_RST};
      gen_wr_o <= 1'b0;
      gen_reg_o <= 3'h0;
      gen_val_o <= `OFS_RST;
    end else begin
      state <= next_state;
      rsp_o <= next_rsp;
      gen_wr_o <= next_gen_wr;
      gen_reg_o <= next_gen_reg;
      gen_val_o <= next_gen_val;
    end
  end

  assign rsp_valid_o = (state == seg_addr_pkg::ST_BUSY);

  // Assertions
  sequence s_req;
    req_valid_i;
  endsequence

  property p_phys_sum;
    @(posedge clk_i) disable iff (!rst_b)
    s_req |=> rsp_valid_o && rsp_o.phys ==
      `PHYS_W'({$past(seg_reg[sel]), 4'h0} + {4'h0, $past(eff_ofs)});
  endproperty
  a_phys_sum: assert property (p_phys_sum) // see [R4] see [R14]
    else $error("physical address wrong");

  property p_fetch_code;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (req_i.kind == seg_addr_pkg::REF_FETCH) |=>
      rsp_o.seg == `SEL_CODE;
  endproperty
  a_fetch_code: assert property (p_fetch_code) // see [R5]
    else $error("fetch not on code segment");

  property p_data_default;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (req_i.kind == seg_addr_pkg::REF_DATA && !req_i.base_is_bp &&
      !req_i.ovr_valid) |=> rsp_o.seg == `SEL_DATA;
  endproperty
  a_data_default: assert property (p_data_default) // see [R6]
    else $error("data ref not on data segment");

  property p_stack;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (req_i.kind == seg_addr_pkg::REF_STACK && !req_i.ovr_valid)
      |=> rsp_o.seg == `SEL_STACK;
  endproperty
  a_stack: assert property (p_stack) // see [R7]
    else $error("stack ref not on stack segment");

  property p_str_dst;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (req_i.kind == seg_addr_pkg::REF_STR_DST) |=>
      rsp_o.seg == `SEL_EXTRA;
  endproperty
  a_str_dst: assert property (p_str_dst) // see [R8]
    else $error("string dest not on extra segment");

  property p_override;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (req_i.kind == seg_addr_pkg::REF_DATA && req_i.ovr_valid)
      |=> rsp_o.seg == $past(req_i.ovr_seg);
  endproperty
  a_override: assert property (p_override) // see [R9]
    else $error("override ignored");

  property p_ptr_load;
    @(posedge clk_i) disable iff (!rst_b)
    ptr_load_valid_i && !ptr_load_i.to_extra |=>
      seg_reg[1] == $past(ptr_load_i.seg_part) && gen_wr_o &&
      gen_val_o == $past(ptr_load_i.ofs_part);
  endproperty
  a_ptr_load: assert property (p_ptr_load) // see [R10] see [R11]
    else $error("pointer load incomplete");

  property p_disp8;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (req_i.disp_is_8) |=>
      rsp_o.offset == `OFS_W'($past(req_i.base)
      + $past(req_i.index) + {{8{$past(req_i.disp[7])}},
      $past(req_i.disp[7:0])});
  endproperty
  a_disp8: assert property (p_disp8) // see [R13] see [R1]
    else $error("offset sum wrong");

  property p_disp16;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (!req_i.disp_is_8) |=>
      rsp_o.offset == `OFS_W'($past(req_i.base) + $past(req_i.index)
      + $past(req_i.disp));
  endproperty
  a_disp16: assert property (p_disp16) // see [R13]
    else $error("16-bit offset sum wrong");

  // Answer stands one cycle, then drops unless asked again
  sequence s_rsp_pulse;
    rsp_valid_o ##1 !rsp_valid_o;
  endsequence

  property p_rsp_pulse;
    @(posedge clk_i) disable iff (!rst_b)
    s_req ##1 !req_valid_i |-> s_rsp_pulse;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) // see [R4]
    else $error("answer not a one-cycle pulse");

  property p_rsp_hold;
    @(posedge clk_i) disable iff (!rst_b)
    !req_valid_i |=> $stable(rsp_o);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) // see [R2]
    else $error("answer changed without request");

  property p_imm_code;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (req_i.kind == seg_addr_pkg::REF_IMM) |=>
      rsp_o.seg == `SEL_CODE;
  endproperty
  a_imm_code: assert property (p_imm_code) // see [R5]
    else $error("immediate not on code segment");

  property p_bp_stack;
    @(posedge clk_i) disable iff (!rst_b)
    s_req and (req_i.kind == seg_addr_pkg::REF_DATA && req_i.base_is_bp &&
      !req_i.ovr_valid) |=> rsp_o.seg == `SEL_STACK;
  endproperty
  a_bp_stack: assert property (p_bp_stack) // see [R7]
    else $error("base pointer ref not on stack segment");

  property p_ptr_extra;
    @(posedge clk_i) disable iff (!rst_b)
    ptr_load_valid_i && ptr_load_i.to_extra |=>
      seg_reg[`SEL_EXTRA] == $past(ptr_load_i.seg_part) && gen_wr_o &&
      gen_reg_o == $past(ptr_load_i.gen_reg);
  endproperty
  a_ptr_extra: assert property (p_ptr_extra) // see [R11]
    else $error("extra pointer load incomplete");

  // Register write stands one cycle per pointer load
  sequence s_wr_pulse;
    gen_wr_o ##1 !gen_wr_o;
  endsequence

  property p_wr_pulse;
    @(posedge clk_i) disable iff (!rst_b)
    ptr_load_valid_i ##1 !ptr_load_valid_i |-> s_wr_pulse;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) // see [R10]
    else $error("register write not a pulse");

  property p_stack_load;
    @(posedge clk_i) disable iff (!rst_b)
    seg_load_valid_i && seg_load_i.seg == `SEL_STACK |=>
      seg_reg[`SEL_STACK] == $past(seg_load_i.value);
  endproperty
  a_stack_load: assert property (p_stack_load) // see [R3]
    else $error("segment load lost");

  property p_seg_isolated;
    @(posedge clk_i) disable iff (!rst_b)
    seg_load_valid_i && seg_load_i.seg == `SEL_STACK && !ptr_load_valid_i
      |=> $stable(seg_reg[`SEL_DATA]) && $stable(seg_reg[`SEL_EXTRA]);
  endproperty
  a_seg_isolated: assert property (p_seg_isolated) // see [R12]
    else $error("segment load disturbed another segment");

endmodule

// ---- src/seg_addr_params.svh ----
/*
 * Constants for the segmented address generator: widths, shift amount,
 * segment register codes and reset values.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef SEG_ADDR_PARAMS_SVH
`define SEG_ADDR_PARAMS_SVH

`define SEG_W 16
`define OFS_W 16
`define PHYS_W 20
`define SEG_SHIFT 4
`define DISP8_W 8
`define SEG_SEL_W 2
`define SEL_CODE 2'h0
`define SEL_DATA 2'h1
`define SEL_STACK 2'h2
`define SEL_EXTRA 2'h3
`define SEG_RST 16'h0000
`define CODE_SEG_RST 16'hFFFF
`define OFS_RST 16'h0000
`define PHYS_RST 20'h00000

`endif

// ---- src/seg_addr_pkg.sv ----
/*
 * Types shared by the segmented address generator, the bus side model and the testbench.
 * Assumes seg_addr_params.svh is on the include path.
 */
`include "seg_addr_params.svh"

package seg_addr_pkg;

  // Kind of memory reference, one-hot
  typedef enum logic [4:0] {
    REF_FETCH = 5'h01,
    REF_IMM = 5'h02,
    REF_DATA = 5'h04,
    REF_STACK = 5'h08,
    REF_STR_DST = 5'h10
  } ref_kind_t;

  typedef logic [`SEG_SEL_W-1:0] seg_sel_t;

  // Request from decode and effective-address logic
  typedef struct packed {
    ref_kind_t kind;
    logic base_is_bp;
    logic ovr_valid;
    seg_sel_t ovr_seg;
    logic [`OFS_W-1:0] base;
    logic [`OFS_W-1:0] index;
    logic [`OFS_W-1:0] disp;
    logic disp_is_8;
  } addr_req_t;

  // Answer toward the bus interface
  typedef struct packed {
    logic [`PHYS_W-1:0] phys;
    seg_sel_t seg;
    logic [`OFS_W-1:0] offset;
  } addr_rsp_t;

  // Segment register load request
  typedef struct packed {
    seg_sel_t seg;
    logic [`SEG_W-1:0] value;
  } seg_load_t;

  // Pointer load: segment into data or extra, offset into a general reg
  typedef struct packed {
    logic to_extra;
    logic [2:0] gen_reg;
    logic [`SEG_W-1:0] seg_part;
    logic [`OFS_W-1:0] ofs_part;
  } ptr_load_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } gen_state_t;

endpackage

// ---- src/phys_adder.sv ----
/*
 * Combinational physical address adder: base shifted left then offset.
 * Assumes inputs come from flip-flops of the same clock.
 */
`timescale 1ns/1ps
`include "seg_addr_params.svh"

module phys_adder (
  input wire logic [`SEG_W-1:0] seg_base_i,
  input wire logic [`OFS_W-1:0] offset_i,
  output logic [`PHYS_W-1:0] phys_o
);

  logic [`PHYS_W-1:0] shifted;
  logic [`PHYS_W-1:0] ofs_ext;

  always_comb begin
    shifted = {seg_base_i, {`SEG_SHIFT{1'b0}}};
    ofs_ext = {{(`PHYS_W-`OFS_W){1'b0}}, offset_i};
    // Carry out of bit 19 dropped, wraps in 1 MB, see [R4] see [R14]
    phys_o = shifted + ofs_ext;
  end

endmodule

// ---- testbench/bus_side_model.sv ----
/*
 * Bus interface side of the address generator: latches every answer.
 * Assumes answers arrive as one-cycle valid pulses on clk_i.
 */
`timescale 1ns/1ps
module bus_side_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic rsp_valid_i,
  input wire seg_addr_pkg::addr_rsp_t rsp_i,
  output seg_addr_pkg::addr_rsp_t seen_o,
  output logic [7:0] seen_count_o
);
  // Answer latched and counted on each valid answer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen_o <= '0;
      seen_count_o <= 8'h00;
    end else if (rsp_valid_i) begin
      seen_o <= rsp_i;
      seen_count_o <= seen_count_o + 8'h01;
    end
  end
endmodule

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench for seg_addr_gen with a bus side model.
 * Assumes inputs driven on falling edges and one answer per request.
 */
`timescale 1ns/1ps
`include "seg_addr_params.svh"
module testbench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_valid_i = 1'b0;
  seg_addr_pkg::addr_req_t req_i = '0;
  logic seg_load_valid_i = 1'b0;
  seg_addr_pkg::seg_load_t seg_load_i = '0;
  logic ptr_load_valid_i = 1'b0;
  seg_addr_pkg::ptr_load_t ptr_load_i = '0;
  logic rsp_valid_o;
  seg_addr_pkg::addr_rsp_t rsp_o;
  logic gen_wr_o;
  logic [2:0] gen_reg_o;
  logic [`OFS_W-1:0] gen_val_o;
  seg_addr_pkg::addr_rsp_t seen;
  logic [7:0] seen_count;
  logic [15:0] segv [4] = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  localparam seg_addr_pkg::ref_kind_t kind_fetch = seg_addr_pkg::REF_FETCH;
  localparam seg_addr_pkg::ref_kind_t kind_imm = seg_addr_pkg::REF_IMM;
  localparam seg_addr_pkg::ref_kind_t kind_data = seg_addr_pkg::REF_DATA;
  localparam seg_addr_pkg::ref_kind_t kind_stack = seg_addr_pkg::REF_STACK;
  localparam seg_addr_pkg::ref_kind_t kind_str_dst = seg_addr_pkg::REF_STR_DST;

  always #50 clk_i = ~clk_i;

  seg_addr_gen dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid_i), .req_i(req_i),
    .seg_load_valid_i(seg_load_valid_i), .seg_load_i(seg_load_i),
    .ptr_load_valid_i(ptr_load_valid_i), .ptr_load_i(ptr_load_i),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .gen_wr_o(gen_wr_o),
    .gen_reg_o(gen_reg_o), .gen_val_o(gen_val_o));
  bus_side_model bus_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o), .seen_o(seen),
    .seen_count_o(seen_count));

  task give_verdict;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task check_rsp(input seg_addr_pkg::addr_rsp_t got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task check_val(input logic [19:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task send(input seg_addr_pkg::ref_kind_t k, input logic bp, ov,
            input logic [1:0] os, input logic [15:0] b, x, d,
            input logic d8, input logic [1:0] sel);
    logic [15:0] o;
    logic [7:0] cnt;
    seg_addr_pkg::addr_rsp_t e;
    o = b + x + (d8 ? {{8{d[7]}}, d[7:0]} : d);
    e = '{phys: {segv[sel], 4'h0} + {4'h0, o}, seg: sel, offset: o};
    cnt = seen_count;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_i = '{kind: k, base_is_bp: bp, ovr_valid: ov, ovr_seg: os,
      base: b, index: x, disp: d, disp_is_8: d8};
    @(negedge clk_i);
    req_valid_i = 1'b0;
    check_val({19'h0, rsp_valid_o}, 20'h00001);
    @(negedge clk_i);
    check_val({19'h0, rsp_valid_o}, 20'h00000);
    check_val({12'h0, seen_count - cnt}, 20'h00001);
    check_rsp(seen, e);
  endtask

  // Mode bits: base_is_bp, ovr_valid, ovr_seg
  task rq(input seg_addr_pkg::ref_kind_t k, input logic [3:0] m,
          input logic [15:0] b, input logic [1:0] sel);
    send(k, m[3], m[2], m[1:0], b, 16'h0000, 16'h0000, 1'b0, sel);
  endtask

  task rq_sum(input logic [15:0] b, x, d, input logic d8);
    send(seg_addr_pkg::REF_DATA, 1'b0, 1'b0, 2'h0, b, x, d, d8, `SEL_DATA);
  endtask

  task ld(input logic [1:0] s, input logic [15:0] v);
    @(negedge clk_i);
    seg_load_valid_i = 1'b1;
    seg_load_i = '{seg: s, value: v};
    segv[s] = v;
    @(negedge clk_i);
    seg_load_valid_i = 1'b0;
  endtask

  task ptr(input logic te, input logic [2:0] g, input logic [15:0] s, o);
    @(negedge clk_i);
    ptr_load_valid_i = 1'b1;
    ptr_load_i = '{to_extra: te, gen_reg: g, seg_part: s, ofs_part: o};
    @(negedge clk_i);
    ptr_load_valid_i = 1'b0;
    check_val({gen_wr_o, gen_reg_o, gen_val_o}, {1'b1, g, o});
    segv[te ? `SEL_EXTRA : `SEL_DATA] = s;
    @(negedge clk_i);
    check_val({19'h0, gen_wr_o}, 20'h00000);
  endtask

  task t_reset_and_select;
    rq(kind_fetch, 4'h0, 16'h0010, `SEL_CODE);
    ld(`SEL_CODE, 16'h1000);
    ld(`SEL_DATA, 16'h2000);
    ld(`SEL_STACK, 16'h3000);
    ld(`SEL_EXTRA, 16'h4000);
    rq(kind_fetch, 4'h0, 16'h0123, `SEL_CODE);
    rq(kind_imm, 4'h0, 16'h0456, `SEL_CODE);
    rq(kind_data, 4'h0, 16'h0789, `SEL_DATA);
    rq(kind_data, 4'h8, 16'h0ABC, `SEL_STACK);
    rq(kind_stack, 4'h0, 16'h0DEF, `SEL_STACK);
    rq(kind_str_dst, 4'h0, 16'h0F00, `SEL_EXTRA);
    $display("test reset_and_select done");
  endtask

  task t_override;
    rq(kind_data, 4'h7, 16'h0011, `SEL_EXTRA);
    rq(kind_data, 4'hC, 16'h0022, `SEL_CODE);
    rq(kind_fetch, 4'h7, 16'h0033, `SEL_CODE);
    rq(kind_str_dst, 4'h5, 16'h0044, `SEL_EXTRA);
    rq(kind_stack, 4'h5, 16'h0055, `SEL_STACK);
    rq(kind_stack, 4'hD, 16'h0066, `SEL_DATA);
    $display("test override done");
  endtask

  task t_offset;
    rq_sum(16'hFFFF, 16'h0002, 16'h0080, 1'b1);
    rq_sum(16'hFFFF, 16'h0002, 16'h0080, 1'b0);
    ld(`SEL_CODE, 16'hFFFF);
    rq(kind_fetch, 4'h0, 16'hFFFF, `SEL_CODE);
    $display("test offset done");
  endtask

  task t_pointer_and_equal;
    ptr(1'b0, 3'h5, 16'h1234, 16'h5678);
    rq(kind_data, 4'h0, 16'h0001, `SEL_DATA);
    ptr(1'b1, 3'h7, 16'hABCD, 16'h0F0F);
    rq(kind_str_dst, 4'h0, 16'h0002, `SEL_EXTRA);
    ld(`SEL_DATA, 16'h5555);
    ld(`SEL_STACK, 16'h5555);
    ld(`SEL_EXTRA, 16'h5555);
    rq(kind_data, 4'h0, 16'h0100, `SEL_DATA);
    rq(kind_stack, 4'h0, 16'h0100, `SEL_STACK);
    $display("test pointer_and_equal done");
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      give_verdict;
    end
  end

  initial begin
    repeat (4) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_reset_and_select;
    t_override;
    t_offset;
    t_pointer_and_equal;
    give_verdict;
  end
endmodule
